// [external_irq_pin_detector.sv]
// External interrupt request pin detector with AXI4-Lite register access
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module external_irq_pin_detector (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Request pin and pad control
  input  wire logic        irq_pin,
  output logic             pull_enable,
  output logic             pull_down_select,
  // Interrupts
  output logic             cpu_irq_req,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic        flag_q;
  logic        flag_d;
  logic        pin_prev_q;
  logic        pin_prev_d;
  logic        sts_q;
  logic        sts_d;
  logic        ien_q;
  logic        ien_d;
  logic        aw_held_q;
  logic        aw_held_d;
  logic [3:0]  awaddr_q;
  logic [3:0]  awaddr_d;
  logic        w_held_q;
  logic        w_held_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [3:0]  wstrb_q;
  logic [3:0]  wstrb_d;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;

  logic        pin_s;
  logic        pe;
  logic        edg;
  logic        mode;
  logic        pin_active;
  logic        edge_hit;
  logic        event_hit;
  logic        wr_fire;
  logic        ack_wr;
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  pin_sync u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      (irq_pin),
    .dout     (pin_s)
  );

  assign pe   = ctrl_q[irq_pin_pkg::pin_function_enable_bit];
  assign edg  = ctrl_q[irq_pin_pkg::edge_polarity_select_bit];
  assign mode = ctrl_q[irq_pin_pkg::detection_mode_bit];

  ////////////////////////////////////////////////////////////////////////////
  // Detection
  // Active level follows the polarity select
  assign pin_active = edg ? pin_s : ~pin_s;
  assign edge_hit   = edg ? (pin_s & ~pin_prev_q) : (~pin_s & pin_prev_q);
  // Level mode keeps re-asserting the event while the pin sits asserted
  assign event_hit  = pe & (edge_hit | (mode & pin_active));

  // Pad pull: on when enabled and not disabled, direction from polarity
  assign pull_enable      = pe & ~ctrl_q[irq_pin_pkg::pull_disable_bit];
  assign pull_down_select = pe & edg;

  assign cpu_irq_req = flag_q & ctrl_q[irq_pin_pkg::request_interrupt_enable_bit];
  assign irq         = sts_q & ien_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;
  assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  assign wr_fire = ~bvalid_q & (aw_held_q | s_axi_awvalid) & (w_held_q | s_axi_wvalid);
  assign ack_wr  = wr_fire & (wr_addr == irq_pin_pkg::ctrl_addr) & wr_strb[0]
                   & wr_data[irq_pin_pkg::request_acknowledge_bit];

  always_comb begin
    aw_held_d = aw_held_q;
    awaddr_d  = awaddr_q;
    w_held_d  = w_held_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    ctrl_d    = ctrl_q;
    ien_d     = ien_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = irq_pin_pkg::resp_okay;
      if (wr_addr == irq_pin_pkg::ctrl_addr) begin
        if (wr_strb[0]) begin
          // Flag and acknowledge are not stored as control
          ctrl_d = wr_data[7:0] & 8'h73;
        end
      end else if (wr_addr == irq_pin_pkg::int_enable_addr) begin
        if (wr_strb[0]) begin
          ien_d = wr_data[0];
        end
      end else if (wr_addr == irq_pin_pkg::int_clear_addr) begin
        bresp_d = irq_pin_pkg::resp_okay;
      end else if (wr_addr == irq_pin_pkg::int_status_addr) begin
        bresp_d = irq_pin_pkg::resp_okay;
      end else begin
        bresp_d = irq_pin_pkg::resp_slverr;
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request flag and sticky status
  always_comb begin
    pin_prev_d = pin_s;
    flag_d     = flag_q;
    sts_d      = sts_q;
    // Set wins over acknowledge; in level mode an asserted pin re-sets it
    if (ack_wr) begin
      flag_d = 1'b0;
    end
    if (event_hit) begin
      flag_d = 1'b1;
    end
    if (wr_fire && wr_addr == irq_pin_pkg::int_clear_addr && wr_strb[0] && wr_data[0]) begin
      sts_d = 1'b0;
    end
    if (event_hit) begin
      sts_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  assign s_axi_arready = ~rvalid_q;

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = irq_pin_pkg::resp_okay;
      rdata_d  = 32'h0000_0000;
      if (s_axi_araddr == irq_pin_pkg::ctrl_addr) begin
        // Acknowledge bit reads as zero
        rdata_d[7:0] = ctrl_q | {4'h0, flag_q, 3'h0};
      end else if (s_axi_araddr == irq_pin_pkg::int_status_addr) begin
        rdata_d[0] = sts_q;
      end else if (s_axi_araddr == irq_pin_pkg::int_enable_addr) begin
        rdata_d[0] = ien_q;
      end else if (s_axi_araddr == irq_pin_pkg::int_clear_addr) begin
        rdata_d = 32'h0000_0000;
      end else begin
        rresp_d = irq_pin_pkg::resp_slverr;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= irq_pin_pkg::ctrl_reset;
      flag_q     <= 1'b0;
      pin_prev_q <= 1'b0;
      sts_q      <= 1'b0;
      ien_q      <= 1'b0;
      aw_held_q  <= 1'b0;
      awaddr_q   <= 4'h0;
      w_held_q   <= 1'b0;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= irq_pin_pkg::resp_okay;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= irq_pin_pkg::resp_okay;
    end else begin
      ctrl_q     <= ctrl_d;
      flag_q     <= flag_d;
      pin_prev_q <= pin_prev_d;
      sts_q      <= sts_d;
      ien_q      <= ien_d;
      aw_held_q  <= aw_held_d;
      awaddr_q   <= awaddr_d;
      w_held_q   <= w_held_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_pull_control: assert property (@(posedge core_clk) disable iff (!rst_n)
    pull_enable == (pe && !ctrl_q[irq_pin_pkg::pull_disable_bit]))
    else $error("pull enable wrong");
  a_pull_direction: assert property (@(posedge core_clk) disable iff (!rst_n)
    pe |-> (pull_down_select == edg))
    else $error("pull direction wrong");
  a_pull_on_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(pe) && !ctrl_q[irq_pin_pkg::pull_disable_bit] |-> pull_enable)
    else $error("pull not on after enable");
  a_disabled_no_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pe && !flag_q |=> !flag_q)
    else $error("flag set while disabled");
  a_edge_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    pe && edg && pin_s && !pin_prev_q |=> flag_q)
    else $error("rising edge missed");
  a_fall_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    pe && !edg && !pin_s && pin_prev_q |=> flag_q)
    else $error("falling edge missed");
  a_ack_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    ack_wr && !event_hit |=> !flag_q)
    else $error("acknowledge did not clear");
  a_level_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    pe && mode && pin_active |=> flag_q)
    else $error("level flag cleared while asserted");
  a_cpu_request: assert property (@(posedge core_clk) disable iff (!rst_n)
    flag_q && ctrl_q[irq_pin_pkg::request_interrupt_enable_bit] |-> cpu_irq_req)
    else $error("cpu request missing");
  a_edge_only_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    flag_q && !ack_wr |=> flag_q)
    else $error("flag dropped without acknowledge");
  a_sync_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(rst_n, 2) |-> pin_s == $past(irq_pin, 2))
    else $error("synchroniser delay wrong");

  // Decode and pad checks; the synchroniser makes every pin event two edges late
  a_ack_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_rvalid |-> !s_axi_rdata[irq_pin_pkg::request_acknowledge_bit])
    else $error("acknowledge bit read back as one");
  a_ack_zero_noop: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_fire && !wr_data[irq_pin_pkg::request_acknowledge_bit] |-> !ack_wr)
    else $error("acknowledge taken from a zero write");
  a_pull_off_disabled: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pe |-> !pull_enable && !pull_down_select)
    else $error("pull active with pin disabled");
  a_pull_up_falling: assert property (@(posedge core_clk) disable iff (!rst_n)
    pe && !edg |-> !pull_down_select)
    else $error("pulldown chosen for falling polarity");
  a_level_event: assert property (@(posedge core_clk) disable iff (!rst_n)
    pe && mode && pin_active |-> event_hit)
    else $error("level mode missed an asserted pin");
  a_edge_only_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    pe && !mode && !edge_hit |-> !event_hit)
    else $error("edge-only mode saw an event without an edge");
  a_masked_request: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctrl_q[irq_pin_pkg::request_interrupt_enable_bit] |-> !cpu_irq_req)
    else $error("cpu request while masked");
  a_low_level_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    pe && mode && !edg && !pin_s |=> flag_q)
    else $error("low level missed");
  a_flag_source: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(flag_q) |-> $past(event_hit))
    else $error("flag set without an event");
  a_status_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_fire && wr_addr == irq_pin_pkg::int_clear_addr && wr_strb[0] && wr_data[0] && !event_hit |=> !sts_q)
    else $error("status clear ignored");
  c_edge_event: cover property (@(posedge core_clk) disable iff (!rst_n) pe && !mode && edge_hit);
  c_level_event: cover property (@(posedge core_clk) disable iff (!rst_n) pe && mode && pin_active && ack_wr);
  c_cpu_irq: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(cpu_irq_req));
  c_rise_event: cover property (@(posedge core_clk) disable iff (!rst_n) pe && edg && edge_hit);
  c_status_clear: cover property (@(posedge core_clk) disable iff (!rst_n) sts_q && !sts_d);
endmodule

// [irq_pin_pkg.sv]
// Package: register map, field positions and reset values of the external request pin detector
package irq_pin_pkg;
  // Register byte addresses
  localparam logic [3:0] ctrl_addr      = 4'h0;
  localparam logic [3:0] int_status_addr = 4'h4;
  localparam logic [3:0] int_enable_addr = 4'h8;
  localparam logic [3:0] int_clear_addr  = 4'hc;
  // Field positions of irq_pin_status_control
  localparam int pull_disable_bit          = 6;
  localparam int edge_polarity_select_bit  = 5;
  localparam int pin_function_enable_bit   = 4;
  localparam int request_flag_bit          = 3;
  localparam int request_acknowledge_bit   = 2;
  localparam int request_interrupt_enable_bit = 1;
  localparam int detection_mode_bit        = 0;
  // Reset values
  localparam logic [7:0] ctrl_reset       = 8'h00;
  localparam logic [1:0] sync_reset       = 2'h0;
  // AXI responses
  localparam logic [1:0] resp_okay        = 2'h0;
  localparam logic [1:0] resp_slverr      = 2'h2;
endpackage

// [irq_source_model.sv]
// Model of the external device driving the request pin, with the pad pull
`timescale 1ns/100ps
module irq_source_model (
  // Clock
  input  wire logic core_clk,
  // Drive from the bench
  input  wire logic drive_en,
  input  wire logic drive_val,
  // Pad control from the detector
  input  wire logic pull_enable,
  input  wire logic pull_down_select,
  // Pin
  output logic      pin
);
  logic last_q = 1'b1;

  always_ff @(posedge core_clk) begin
    if (drive_en) begin
      last_q <= drive_val;
    end
  end

  // Released pin: pull level if a pull is on, else an undriven line shows a changed value
  always_comb begin
    if (drive_en) begin
      pin = drive_val;
    end else if (pull_enable) begin
      pin = !pull_down_select;
    end else begin
      pin = !last_q;
    end
  end
endmodule

// [pin_sync.sv]
// Two-flop synchroniser for the request pin
`timescale 1ns/100ps
module pin_sync (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Data
  input  wire logic din,
  output logic      dout
);
  logic [1:0] sync_q;
  logic [1:0] sync_d;

  always_comb begin
    sync_d = {sync_q[0], din};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= irq_pin_pkg::sync_reset;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q[1];
endmodule

// [testbench.sv]
// Self-checking bench for the external request pin detector
`timescale 1ns/100ps
module testbench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic drive_en = 1'b1, drive_val = 1'b1;
  logic pin, pull_enable, pull_down_select, cpu_irq_req, irq;
  logic [31:0] rd;
  int error_cnt = 0, n_tests = 0, cyc = 0;

  always #2.5 core_clk = ~core_clk;

  external_irq_pin_detector i_dut (
    .core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_pin(pin), .pull_enable(pull_enable), .pull_down_select(pull_down_select),
    .cpu_irq_req(cpu_irq_req), .irq(irq));

  irq_source_model i_src (
    .core_clk(core_clk), .drive_en(drive_en), .drive_val(drive_val),
    .pull_enable(pull_enable), .pull_down_select(pull_down_select), .pin(pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (awvalid && awready) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (!rvalid);
    d = rdata;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    rd_reg(a, rd);
    check("register", rd, exp);
  endtask

  // Pin change then the synchroniser and detector latency
  task automatic drive(input logic en, input logic v);
    drive_en <= en;
    drive_val <= v;
    repeat (6) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd_chk(irq_pin_pkg::ctrl_addr, {24'h0, irq_pin_pkg::ctrl_reset});
    check("pull_enable", pull_enable, 1'b0);
    wr(4'h0, 32'h10);
    check("pull_enable", pull_enable, 1'b1);
    check("pull_down", pull_down_select, 1'b0);
    drive(1'b0, 1'b1);
    rd_chk(4'h0, 32'h10);
    drive(1'b1, 1'b0);
    rd_chk(4'h0, 32'h18);
    check("cpu_irq_req", cpu_irq_req, 1'b0);
    wr(4'h0, 32'h12);
    check("cpu_irq_req", cpu_irq_req, 1'b1);
    wr(4'h0, 32'h12);
    rd_chk(4'h0, 32'h1a);
    wr(4'h0, 32'h16);
    rd_chk(4'h0, 32'h12);
    check("cpu_irq_req", cpu_irq_req, 1'b0);
    wr(4'h0, 32'h52);
    check("pull_enable", pull_enable, 1'b0);
    wr(4'h0, 32'h32);
    check("pull_enable", pull_enable, 1'b1);
    check("pull_down", pull_down_select, 1'b1);
    drive(1'b0, 1'b0);
    rd_chk(4'h0, 32'h32);
    drive(1'b1, 1'b1);
    rd_chk(4'h0, 32'h3a);
    wr(4'h0, 32'h36);
    wr(4'h0, 32'h33);
    rd_chk(4'h0, 32'h3b);
    wr(4'h0, 32'h37);
    rd_chk(4'h0, 32'h3b);
    drive(1'b1, 1'b0);
    wr(4'h0, 32'h37);
    rd_chk(4'h0, 32'h33);
    wr(4'h0, 32'h13);
    rd_chk(4'h0, 32'h1b);
    drive(1'b1, 1'b1);
    wr(4'h0, 32'h17);
    rd_chk(4'h0, 32'h13);
    wr(4'h0, 32'h02);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
    rd_chk(4'h0, 32'h02);
    check("cpu_irq_req", cpu_irq_req, 1'b0);
    // Sticky event status, enable and write-one clear
    rd_chk(irq_pin_pkg::int_status_addr, 32'h1);
    wr(irq_pin_pkg::int_clear_addr, 32'h1);
    rd_chk(irq_pin_pkg::int_status_addr, 32'h0);
    wr(irq_pin_pkg::int_enable_addr, 32'h1);
    rd_chk(irq_pin_pkg::int_enable_addr, 32'h1);
    check("irq", irq, 1'b0);
    wr(4'h0, 32'h10);
    drive(1'b1, 1'b0);
    check("irq", irq, 1'b1);
    wr(irq_pin_pkg::int_enable_addr, 32'h0);
    check("irq", irq, 1'b0);
    wr(irq_pin_pkg::int_enable_addr, 32'h1);
    check("irq", irq, 1'b1);
    wr(irq_pin_pkg::int_clear_addr, 32'h1);
    check("irq", irq, 1'b0);
    // Unmapped address answers with an error
    rd_reg(4'h2, rd);
    check("rresp", {30'h0, rresp}, {30'h0, irq_pin_pkg::resp_slverr});
    wr(4'h2, 32'h7f);
    check("bresp", {30'h0, bresp}, {30'h0, irq_pin_pkg::resp_slverr});
    rd_chk(4'h0, 32'h18);
    complete_run();
  end
endmodule
